// ---- rtl/exc_seq_pkg.sv ----
// constants and carrier types of the exception sequencer
// assumes a single 25 MHz system clock shared with the core pipeline
package exc_seq_pkg;
  localparam int ADDR_W      = 4;
  localparam int DATA_W      = 16;
  localparam int PC_W        = 24;
  localparam int NUM_SRC     = 16;
  localparam int STACK_DEPTH = 8;
  localparam int SP_W        = 3;

  // register indices on the plain register port
  localparam logic [ADDR_W-1:0] REG_CTRL        = 4'h0;
  localparam logic [ADDR_W-1:0] REG_STATUS      = 4'h1;
  localparam logic [ADDR_W-1:0] REG_FLAGS       = 4'h2;
  localparam logic [ADDR_W-1:0] REG_ENABLES     = 4'h3;
  localparam logic [ADDR_W-1:0] REG_RESET_CTRL  = 4'h4;
  localparam logic [ADDR_W-1:0] REG_STACK_LIMIT = 4'h5;
  localparam logic [ADDR_W-1:0] REG_TRAPS       = 4'h6;

  // control register fields
  localparam int CTRL_ALT_BIT     = 0;
  localparam int CTRL_OVF31_EN    = 1;
  localparam int CTRL_OVF39_EN    = 2;
  localparam int CTRL_W           = 3;

  // reset control register fields
  localparam int RC_WDT      = 0;
  localparam int RC_UNINIT   = 1;
  localparam int RC_ILLEGAL  = 2;
  localparam int RC_BROWNOUT = 3;
  localparam int RC_POR      = 4;
  localparam int RC_CONFLICT = 15;

  // trap pending bits
  localparam int TRAP_MATH  = 0;
  localparam int TRAP_ADDR  = 1;
  localparam int TRAP_STACK = 2;
  localparam int TRAP_OSC   = 3;
  localparam int NUM_TRAP   = 4;

  localparam logic [3:0] LVL_MATH     = 4'hb;
  localparam logic [3:0] LVL_ADDR     = 4'hc;
  localparam logic [3:0] LVL_STACK    = 4'hd;
  localparam logic [3:0] LVL_OSC      = 4'he;
  localparam logic [3:0] LVL_HARD_MIN = 4'hc;
  localparam logic [3:0] LVL_TRAP_MIN = 4'h8;

  localparam logic [PC_W-1:0]   RESET_VECTOR     = 24'h00_0000;
  localparam logic [PC_W-1:0]   PRIMARY_VEC_BASE = 24'h00_0004;
  localparam logic [PC_W-1:0]   ALT_VEC_BASE     = 24'h00_0104;
  localparam logic [5:0]        IRQ_VEC_FIRST   = 6'h08;
  localparam logic [DATA_W-1:0] STACK_UNDERFLOW = 16'h0800;

  localparam logic [DATA_W-1:0] RESET_CTRL_RST  = 16'h0010;
  localparam logic [DATA_W-1:0] STACK_LIMIT_RST = 16'hfffe;
  localparam logic [3:0]        LEVEL_RST       = 4'h0;

  typedef struct packed {
    logic [PC_W-1:0] pc;
    logic            lvl_msb;
    logic [7:0]      status_low_byte;
  } stack_frame_t;

  typedef enum logic [1:0] {ST_RESET, ST_FETCH0, ST_RUN} seq_state_t;
endpackage : exc_seq_pkg

// ---- rtl/reset_trap_interrupt_sequencer.sv ----
// reset, trap and interrupt sequencing for a 16-bit signal controller core
// assumes the core pulses instr_start_in at each instruction boundary,
// after the previous instruction has completed, and reports error events
`timescale 1ns/10ps
module reset_trap_interrupt_sequencer (
  input  wire logic                     clk_in,
  input  wire logic                     nrst_in,
  // register port
  input  wire logic [3:0]               reg_addr_in,
  input  wire logic [15:0]              reg_wdata_in,
  input  wire logic                     reg_wr_in,
  input  wire logic                     reg_rd_in,
  output logic      [15:0]              reg_rdata_out,
  // core pipeline
  input  wire logic                     instr_start_in,
  input  wire logic [23:0]              pc_in,
  input  wire logic [7:0]               status_low_in,
  input  wire logic                     return_from_interrupt_op_in,
  // reset sources
  input  wire logic                     wdt_timeout_in,
  input  wire logic                     uninit_pointer_in,
  input  wire logic                     illegal_op_exec_in,
  input  wire logic                     illegal_op_flushed_in,
  input  wire logic                     brownout_reset_in,
  // trap sources
  input  wire logic                     div_zero_in,
  input  wire logic                     shift_oversize_in,
  input  wire logic                     acc_ovf31_in,
  input  wire logic                     acc_guard_used_in,
  input  wire logic                     acc_ovf39_in,
  input  wire logic                     saturation_on_in,
  input  wire logic                     misaligned_in,
  input  wire logic                     unimpl_data_in,
  input  wire logic                     unimpl_prog_in,
  input  wire logic                     vector_space_fetch_in,
  input  wire logic                     multiply_accumulate_class_cross_in,
  input  wire logic                     literal_jump_unimpl_in,
  input  wire logic                     pc_unimpl_exec_in,
  input  wire logic                     sp_load_in,
  input  wire logic [15:0]              sp_value_in,
  input  wire logic                     osc_fail_in,
  // interrupt sources
  input  wire logic [15:0]              irq_event_in,
  input  wire logic [47:0]              irq_priority_in,
  // outputs to core
  output logic                          core_reset_out,
  output logic                          fetch_start_out,
  output logic      [23:0]              fetch_addr_out,
  output logic                          vector_take_out,
  output logic                          hold_out,
  output logic                          div_abort_out,
  output logic                          restore_out,
  output logic      [23:0]              restore_pc_out,
  output logic      [7:0]               restore_status_out,
  output logic      [3:0]               processor_priority_level_out,
  output logic                          trap_level_msb_out
);

  exc_seq_pkg::seq_state_t   state;
  exc_seq_pkg::stack_frame_t stack_mem [exc_seq_pkg::STACK_DEPTH];
  logic [exc_seq_pkg::SP_W-1:0]   sp;
  logic [exc_seq_pkg::CTRL_W-1:0] core_control_reg;
  logic [15:0] interrupt_flag_regs;
  logic [15:0] interrupt_enable_regs;
  logic [15:0] reset_control_reg;
  logic [15:0] stack_limit_value;
  logic [exc_seq_pkg::NUM_TRAP-1:0] trap_pend;

  logic [3:0]  processor_priority_level;
  logic        sys_rst_req;
  logic        conflict;
  logic        err_reset;
  logic [exc_seq_pkg::NUM_TRAP-1:0] trap_new;
  logic        trap_any;
  logic [3:0]  trap_lvl;
  logic [1:0]  trap_idx;
  logic        irq_any;
  logic [2:0]  irq_prio;
  logic [3:0]  irq_idx;
  logic        take_trap;
  logic        take_irq;
  logic        take;
  logic [5:0]  vec_num;
  logic [23:0] next_vec_addr;
  logic [3:0]  hard_pend_top;
  logic [3:0]  new_hard_low;
  logic        ill_exec;

  assign processor_priority_level_out = processor_priority_level;

  // trap detection
  assign ill_exec = illegal_op_exec_in & ~illegal_op_flushed_in;
  always_comb begin
    trap_new = '0;
    trap_new[exc_seq_pkg::TRAP_MATH] = div_zero_in | shift_oversize_in
      | (core_control_reg[exc_seq_pkg::CTRL_OVF31_EN] & acc_ovf31_in
         & ~acc_guard_used_in)
      | (core_control_reg[exc_seq_pkg::CTRL_OVF39_EN] & acc_ovf39_in
         & ~saturation_on_in);
    trap_new[exc_seq_pkg::TRAP_ADDR] = misaligned_in | unimpl_data_in
      | unimpl_prog_in | vector_space_fetch_in
      | multiply_accumulate_class_cross_in;
    trap_new[exc_seq_pkg::TRAP_ADDR] = trap_new[exc_seq_pkg::TRAP_ADDR]
      | literal_jump_unimpl_in | pc_unimpl_exec_in;
    trap_new[exc_seq_pkg::TRAP_STACK] = sp_load_in
      & ((sp_value_in > stack_limit_value)
         | (sp_value_in < exc_seq_pkg::STACK_UNDERFLOW));
    trap_new[exc_seq_pkg::TRAP_OSC] = osc_fail_in;
  end

  // fixed trap priority, highest level wins
  always_comb begin
    trap_any = |trap_pend;
    trap_lvl = exc_seq_pkg::LVL_MATH;
    trap_idx = 2'(exc_seq_pkg::TRAP_MATH);
    if (trap_pend[exc_seq_pkg::TRAP_OSC]) begin
      trap_lvl = exc_seq_pkg::LVL_OSC;
      trap_idx = 2'(exc_seq_pkg::TRAP_OSC);
    end else if (trap_pend[exc_seq_pkg::TRAP_STACK]) begin
      trap_lvl = exc_seq_pkg::LVL_STACK;
      trap_idx = 2'(exc_seq_pkg::TRAP_STACK);
    end else if (trap_pend[exc_seq_pkg::TRAP_ADDR]) begin
      trap_lvl = exc_seq_pkg::LVL_ADDR;
      trap_idx = 2'(exc_seq_pkg::TRAP_ADDR);
    end
  end

  // hard trap conflict: a lower hard trap while a higher one is live
  always_comb begin
    hard_pend_top = 4'h0;
    new_hard_low  = 4'hf;
    if (trap_pend[exc_seq_pkg::TRAP_ADDR])  hard_pend_top = exc_seq_pkg::LVL_ADDR;
    if (trap_pend[exc_seq_pkg::TRAP_STACK]) hard_pend_top = exc_seq_pkg::LVL_STACK;
    if (trap_pend[exc_seq_pkg::TRAP_OSC])   hard_pend_top = exc_seq_pkg::LVL_OSC;
    if (processor_priority_level >= exc_seq_pkg::LVL_HARD_MIN && processor_priority_level > hard_pend_top) hard_pend_top = processor_priority_level;
    if (trap_new[exc_seq_pkg::TRAP_OSC])   new_hard_low = exc_seq_pkg::LVL_OSC;
    if (trap_new[exc_seq_pkg::TRAP_STACK]) new_hard_low = exc_seq_pkg::LVL_STACK;
    if (trap_new[exc_seq_pkg::TRAP_ADDR])  new_hard_low = exc_seq_pkg::LVL_ADDR;
  end
  assign conflict = (state == exc_seq_pkg::ST_RUN)
    & (|trap_new[exc_seq_pkg::TRAP_OSC:exc_seq_pkg::TRAP_ADDR])
    & (new_hard_low < hard_pend_top);
  assign err_reset = wdt_timeout_in | uninit_pointer_in | ill_exec
    | brownout_reset_in;
  assign sys_rst_req = (err_reset | conflict) & (state == exc_seq_pkg::ST_RUN);

  // interrupt request selection
  always_comb begin
    irq_any  = 1'b0;
    irq_prio = 3'h0;
    irq_idx  = 4'h0;
    for (int i = exc_seq_pkg::NUM_SRC - 1; i >= 0; i--) begin
      if (interrupt_flag_regs[i] & interrupt_enable_regs[i]) begin
        if (!irq_any || irq_priority_in[3*i +: 3] >= irq_prio) begin
          irq_any  = 1'b1;
          irq_prio = irq_priority_in[3*i +: 3];
          irq_idx  = 4'(i);
        end
      end
    end
  end

  // decision at an instruction boundary
  assign take_trap = (state == exc_seq_pkg::ST_RUN) & instr_start_in & trap_any
    & (trap_lvl > processor_priority_level);
  assign take_irq = (state == exc_seq_pkg::ST_RUN) & instr_start_in & ~take_trap
    & irq_any & ({1'b0, irq_prio} > processor_priority_level);
  assign take = take_trap | take_irq;

  always_comb begin
    if (take_trap) begin
      vec_num = {2'b00, trap_lvl - exc_seq_pkg::LVL_TRAP_MIN};
    end else begin
      vec_num = exc_seq_pkg::IRQ_VEC_FIRST + {2'b00, irq_idx};
    end
    next_vec_addr = (core_control_reg[exc_seq_pkg::CTRL_ALT_BIT]
      ? exc_seq_pkg::ALT_VEC_BASE : exc_seq_pkg::PRIMARY_VEC_BASE)
      + {17'h0_0000, vec_num, 1'b0};
  end

  // sequence state
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state <= exc_seq_pkg::ST_RESET;
    end else if (sys_rst_req) begin
      state <= exc_seq_pkg::ST_RESET;
    end else begin
      case (state)
        exc_seq_pkg::ST_RESET:  state <= exc_seq_pkg::ST_FETCH0;
        exc_seq_pkg::ST_FETCH0: state <= exc_seq_pkg::ST_RUN;
        exc_seq_pkg::ST_RUN:    state <= exc_seq_pkg::ST_RUN;
        default:                state <= exc_seq_pkg::ST_RESET;
      endcase
    end
  end

  // reset and fetch steering to the core
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      core_reset_out  <= 1'b1;
      fetch_start_out <= 1'b0;
      fetch_addr_out  <= exc_seq_pkg::RESET_VECTOR;
      vector_take_out <= 1'b0;
    end else begin
      core_reset_out  <= sys_rst_req;
      fetch_start_out <= (state == exc_seq_pkg::ST_FETCH0) | take;
      vector_take_out <= take;
      if (state != exc_seq_pkg::ST_RUN || sys_rst_req) begin
        fetch_addr_out <= exc_seq_pkg::RESET_VECTOR;
      end else if (take) begin
        fetch_addr_out <= next_vec_addr;
      end
    end
  end

  // processor priority level
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      processor_priority_level <= exc_seq_pkg::LEVEL_RST;
    end else if (sys_rst_req || state == exc_seq_pkg::ST_RESET) begin
      processor_priority_level <= exc_seq_pkg::LEVEL_RST;
    end else if (take_trap) begin
      processor_priority_level <= trap_lvl;
    end else if (take_irq) begin
      processor_priority_level <= {1'b0, irq_prio};
    end else if (return_from_interrupt_op_in) begin
      processor_priority_level <= {stack_mem[sp - 3'h1].lvl_msb, stack_mem[sp - 3'h1].status_low_byte[7:5]};
    end else if (reg_wr_in && reg_addr_in == exc_seq_pkg::REG_STATUS) begin
      processor_priority_level <= {processor_priority_level[3], reg_wdata_in[2:0]};
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      trap_level_msb_out <= 1'b0;
    end else begin
      trap_level_msb_out <= processor_priority_level[3];
    end
  end

  // context stack
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sp                 <= '0;
      restore_out        <= 1'b0;
      restore_pc_out     <= 24'h00_0000;
      restore_status_out <= 8'h00;
    end else begin
      restore_out <= 1'b0;
      if (sys_rst_req || state == exc_seq_pkg::ST_RESET) begin
        sp <= '0;
      end else if (take) begin
        stack_mem[sp] <= '{pc: pc_in, lvl_msb: processor_priority_level[3],
                           status_low_byte: {processor_priority_level[2:0], status_low_in[4:0]}};
        sp <= sp + 3'h1;
      end else if (return_from_interrupt_op_in) begin
        restore_out        <= 1'b1;
        restore_pc_out     <= stack_mem[sp - 3'h1].pc;
        restore_status_out <= stack_mem[sp - 3'h1].status_low_byte;
        sp <= sp - 3'h1;
      end
    end
  end

  // trap pending flags, cleared as the vector is taken; new detection wins
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      trap_pend     <= '0;
      hold_out      <= 1'b0;
      div_abort_out <= 1'b0;
    end else if (sys_rst_req || state != exc_seq_pkg::ST_RUN) begin
      trap_pend     <= '0;
      hold_out      <= 1'b0;
      div_abort_out <= 1'b0;
    end else begin
      for (int t = 0; t < exc_seq_pkg::NUM_TRAP; t++) begin
        if (trap_new[t]) begin
          trap_pend[t] <= 1'b1;
        end else if (take_trap && trap_idx == 2'(t)) begin
          trap_pend[t] <= 1'b0;
        end
      end
      hold_out <= (|trap_new[exc_seq_pkg::TRAP_OSC:exc_seq_pkg::TRAP_ADDR])
        | (|(trap_pend[exc_seq_pkg::TRAP_OSC:exc_seq_pkg::TRAP_ADDR])
           & ~(take_trap && trap_lvl >= exc_seq_pkg::LVL_HARD_MIN));
      div_abort_out <= div_zero_in;
    end
  end

  // interrupt flags and enables; an event beats a clearing write
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      interrupt_flag_regs   <= 16'h0000;
      interrupt_enable_regs <= 16'h0000;
      core_control_reg      <= '0;
      stack_limit_value     <= exc_seq_pkg::STACK_LIMIT_RST;
    end else if (sys_rst_req) begin
      interrupt_flag_regs   <= 16'h0000;
      interrupt_enable_regs <= 16'h0000;
      core_control_reg      <= '0;
      stack_limit_value     <= exc_seq_pkg::STACK_LIMIT_RST;
    end else begin
      if (reg_wr_in && reg_addr_in == exc_seq_pkg::REG_FLAGS) begin
        interrupt_flag_regs <= reg_wdata_in | irq_event_in;
      end else begin
        interrupt_flag_regs <= interrupt_flag_regs | irq_event_in;
      end
      if (reg_wr_in && reg_addr_in == exc_seq_pkg::REG_ENABLES) begin
        interrupt_enable_regs <= reg_wdata_in;
      end
      if (reg_wr_in && reg_addr_in == exc_seq_pkg::REG_CTRL) begin
        core_control_reg <= reg_wdata_in[exc_seq_pkg::CTRL_W-1:0];
      end
      if (reg_wr_in && reg_addr_in == exc_seq_pkg::REG_STACK_LIMIT) begin
        stack_limit_value <= reg_wdata_in;
      end
    end
  end

  // reset cause record, survives the internal reset; cause wins over a clear
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      reset_control_reg <= exc_seq_pkg::RESET_CTRL_RST;
    end else begin
      if (reg_wr_in && reg_addr_in == exc_seq_pkg::REG_RESET_CTRL) begin
        reset_control_reg <= reg_wdata_in;
      end
      if (state == exc_seq_pkg::ST_RUN) begin
        if (wdt_timeout_in)    reset_control_reg[exc_seq_pkg::RC_WDT]     <= 1'b1;
        if (uninit_pointer_in) reset_control_reg[exc_seq_pkg::RC_UNINIT]  <= 1'b1;
        if (ill_exec)          reset_control_reg[exc_seq_pkg::RC_ILLEGAL] <= 1'b1;
        if (brownout_reset_in) reset_control_reg[exc_seq_pkg::RC_BROWNOUT] <= 1'b1;
        if (conflict)          reset_control_reg[exc_seq_pkg::RC_CONFLICT] <= 1'b1;
      end
    end
  end

  // register read, data one cycle after the strobe
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      reg_rdata_out <= 16'h0000;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        exc_seq_pkg::REG_CTRL:        reg_rdata_out <= {13'h0000, core_control_reg};
        exc_seq_pkg::REG_STATUS:      reg_rdata_out <= {12'h000, processor_priority_level};
        exc_seq_pkg::REG_FLAGS:       reg_rdata_out <= interrupt_flag_regs;
        exc_seq_pkg::REG_ENABLES:     reg_rdata_out <= interrupt_enable_regs;
        exc_seq_pkg::REG_RESET_CTRL:  reg_rdata_out <= reset_control_reg;
        exc_seq_pkg::REG_STACK_LIMIT: reg_rdata_out <= stack_limit_value;
        exc_seq_pkg::REG_TRAPS:       reg_rdata_out <= {12'h000, trap_pend};
        default:                      reg_rdata_out <= 16'h0000;
      endcase
    end else begin
      reg_rdata_out <= 16'h0000;
    end
  end

endmodule : reset_trap_interrupt_sequencer

// ---- sim/core_pipe_model.sv ----
// behavioural core pipeline facing the sequencer
// assumes one clock; pace of instruction boundaries set by gap_in
`timescale 1ns/10ps
module core_pipe_model #(
  parameter logic [23:0] START_ADDR = 24'h00_0200
) (
  input  wire logic        clk_in,
  input  wire logic        nrst_in,
  input  wire logic        core_reset_in,
  input  wire logic        fetch_start_in,
  input  wire logic [23:0] fetch_addr_in,
  input  wire logic [3:0]  gap_in,
  output logic             instr_start_out,
  output logic      [23:0] pc_out
);
  logic [3:0] cnt;
  logic       running;
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in || core_reset_in) begin
      running <= 1'b0;
      cnt <= 4'h0;
      instr_start_out <= 1'b0;
      pc_out <= 24'h00_0000;
    end else if (fetch_start_in) begin
      running <= 1'b1;
      cnt <= 4'h0;
      instr_start_out <= 1'b0;
      // word zero holds a jump to the start address
      pc_out <= (fetch_addr_in == 24'h00_0000) ? START_ADDR : fetch_addr_in + START_ADDR;
    end else if (running) begin
      cnt <= (cnt >= gap_in) ? 4'h0 : cnt + 4'h1;
      instr_start_out <= (cnt >= gap_in);
      pc_out <= pc_out + 24'h00_0002;
    end
  end
endmodule : core_pipe_model

// ---- sim/exc_seq_props.sv ----
// port checker for the exception sequencer
// assumes it is bound into reset_trap_interrupt_sequencer
`timescale 1ns/10ps
module exc_seq_props (
  input wire logic        clk_in,
  input wire logic        nrst_in,
  input wire logic        instr_start_in,
  input wire logic        return_from_interrupt_op_in,
  input wire logic        div_zero_in,
  input wire logic        osc_fail_in,
  input wire logic        core_reset_out,
  input wire logic        fetch_start_out,
  input wire logic [23:0] fetch_addr_out,
  input wire logic        vector_take_out,
  input wire logic        hold_out,
  input wire logic        div_abort_out,
  input wire logic        restore_out,
  input wire logic [7:0]  restore_status_out,
  input wire logic [3:0]  processor_priority_level_out,
  input wire logic        trap_level_msb_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  a_reset_fetch_zero: assert property ($fell(core_reset_out) |-> ##1 fetch_start_out
    && fetch_addr_out == 24'h00_0000) else $error("no fetch at zero after reset");
  a_take_on_boundary: assert property (vector_take_out |-> $past(instr_start_in))
    else $error("exception taken off an instruction boundary");
  a_take_raises_level: assert property (vector_take_out |->
    processor_priority_level_out > $past(processor_priority_level_out)) else $error("level");
  a_level7_traps_only: assert property (vector_take_out &&
    $past(processor_priority_level_out) == 4'h7 |-> processor_priority_level_out[3])
    else $error("interrupt taken at level seven");
  a_trap_vector_slot: assert property (vector_take_out && processor_priority_level_out[3] |->
    fetch_addr_out[7:0] == 8'h04 + {4'h0, processor_priority_level_out[2:0], 1'b0})
    else $error("trap vector does not match level");
  a_vector_in_table: assert property (vector_take_out |-> fetch_start_out &&
    fetch_addr_out inside {[24'h00_000a:24'h00_0032], [24'h00_010a:24'h00_0132]})
    else $error("vector outside tables");
  a_msb_marks_trap: assert property (vector_take_out && processor_priority_level_out[3]
    |=> trap_level_msb_out) else $error("trap level msb not set");
  a_div_abort: assert property (div_zero_in |=> div_abort_out)
    else $error("divide not aborted");
  a_hard_trap_holds: assert property (osc_fail_in && !processor_priority_level_out[3]
    |=> hold_out) else $error("hard trap did not hold");
  a_hold_until_ack: assert property ($fell(hold_out) |-> vector_take_out || core_reset_out
    || $past(core_reset_out)) else $error("hold released without take");
  a_return_restores: assert property (return_from_interrupt_op_in |=> restore_out &&
    processor_priority_level_out[2:0] == restore_status_out[7:5]) else $error("bad return");
endmodule : exc_seq_props
bind reset_trap_interrupt_sequencer exc_seq_props u_props (.clk_in, .nrst_in, .instr_start_in,
  .return_from_interrupt_op_in, .div_zero_in, .osc_fail_in, .core_reset_out, .fetch_start_out,
  .fetch_addr_out, .vector_take_out, .hold_out, .div_abort_out, .restore_out,
  .restore_status_out, .processor_priority_level_out, .trap_level_msb_out);

// ---- sim/testbench.sv ----
// self-checking bench for the exception sequencer
// assumes the core model paces instruction boundaries and follows fetches
`timescale 1ns/10ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_mismatch++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module testbench;
  logic        clk_in = 1'b0, nrst_in = 1'b0, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
  logic [3:0]  reg_addr_in = 4'h0, gap = 4'h2, s;
  logic [15:0] reg_wdata_in = 16'h0000, sp_value = 16'h0000, irq_ev = 16'h0000, e16;
  logic [19:0] ev = 20'h0_0000;
  logic [47:0] irq_pri = 48'h0;
  logic [7:0]  status_low_in = 8'h00;
  logic [31:0] rnd = 32'd85;
  logic        ret = 1'b0, rd_seen = 1'b0;
  logic [23:0] e24, exp_v, faddr, pc, pc_d, pc_sv, rpc;
  logic        core_rst, fstart, vtake, instr, rst_o;
  logic [15:0] rdata;
  int          n_mismatch = 0, checked = 0;
  logic [23:0] vq[$];
  logic [15:0] rq[$];
  core_pipe_model u_core (.clk_in, .nrst_in, .core_reset_in(core_rst), .fetch_start_in(fstart),
    .fetch_addr_in(faddr), .gap_in(gap), .instr_start_out(instr), .pc_out(pc));
  reset_trap_interrupt_sequencer u_dut (.clk_in, .nrst_in, .reg_addr_in, .reg_wdata_in,
    .reg_wr_in, .reg_rd_in, .reg_rdata_out(rdata), .instr_start_in(instr), .pc_in(pc),
    .status_low_in, .return_from_interrupt_op_in(ret), .wdt_timeout_in(ev[15]),
    .uninit_pointer_in(ev[16]), .illegal_op_exec_in(ev[17]), .illegal_op_flushed_in(ev[18]),
    .brownout_reset_in(ev[19]), .div_zero_in(ev[0]), .shift_oversize_in(ev[1]),
    .acc_ovf31_in(ev[2]), .acc_guard_used_in(ev[3]), .acc_ovf39_in(ev[4]),
    .saturation_on_in(ev[5]), .misaligned_in(ev[6]), .unimpl_data_in(ev[7]),
    .unimpl_prog_in(ev[8]), .vector_space_fetch_in(ev[9]),
    .multiply_accumulate_class_cross_in(ev[10]), .literal_jump_unimpl_in(ev[11]),
    .pc_unimpl_exec_in(ev[12]), .sp_load_in(ev[13]), .sp_value_in(sp_value),
    .osc_fail_in(ev[14]), .irq_event_in(irq_ev), .irq_priority_in(irq_pri),
    .core_reset_out(core_rst), .fetch_start_out(fstart), .fetch_addr_out(faddr),
    .vector_take_out(vtake), .hold_out(), .div_abort_out(), .restore_out(rst_o),
    .restore_pc_out(rpc), .restore_status_out(), .processor_priority_level_out(),
    .trap_level_msb_out());
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  task automatic test_done;
    if (n_mismatch == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
    @(posedge clk_in);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    rq.push_back(e);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    repeat (2) @(posedge clk_in);
  endtask : rd
  // pulse sources; an expected vector is awaited, flags cleared and returned from
  task automatic fire(input logic [15:0] i, input logic [19:0] e, input logic [15:0] sp,
                      input logic [23:0] x);
    if (x != 24'h00_0000) vq.push_back(x);
    irq_ev <= i;
    ev <= e;
    sp_value <= sp;
    @(posedge clk_in);
    irq_ev <= 16'h0000;
    ev <= 20'h0_0000;
    for (int n = 0; n < 60 && vq.size() > 0; n++) @(posedge clk_in);
    if (vq.size() > 0) `CHK(vq.size(), 0)
    vq.delete();
    repeat (10) @(posedge clk_in);
    if (x != 24'h00_0000) begin
      wr(exc_seq_pkg::REG_FLAGS, 16'h0000);
      ret <= 1'b1;
      @(posedge clk_in);
      ret <= 1'b0;
      @(posedge clk_in);
    end
  endtask : fire
  always @(posedge clk_in) begin
    if (vtake === 1'b1) begin
      if (vq.size() > 0) e24 = vq.pop_front();
      else e24 = 24'hff_ffff;
      `CHK(faddr, e24)
      pc_sv = pc_d;
    end
    if (rst_o === 1'b1) `CHK(rpc, pc_sv)
    pc_d = pc;
    if (rd_seen) e16 = rq.pop_front();
    if (rd_seen) `CHK(rdata, e16)
    rd_seen = reg_rd_in;
  end
  initial forever #20 clk_in = ~clk_in;
  initial begin
    #(40 * 20000);
    n_mismatch++;
    test_done();
  end
  initial begin
    repeat (6) @(posedge clk_in);
    nrst_in <= 1'b1;
    @(posedge clk_in);
    rd(exc_seq_pkg::REG_RESET_CTRL, 16'h0010);
    rd(exc_seq_pkg::REG_STACK_LIMIT, 16'hfffe);
    rd(4'hf, 16'h0000);
    wr(exc_seq_pkg::REG_CTRL, 16'h0006);
    for (int k = 0; k < 5; k++) if (k != 3) fire(0, 20'h1 << k, 0, 24'h00_000a);
    for (int k = 6; k < 13; k++) fire(0, 20'h1 << k, 0, 24'h00_000c);
    wr(exc_seq_pkg::REG_STACK_LIMIT, 16'h1000);
    fire(0, 20'h0_2000, 16'h1002, 24'h00_000e);
    fire(0, 20'h0_2000, 16'h07fe, 24'h00_000e);
    fire(0, 20'h0_2000, 16'h0800, 24'h00_0000);
    fire(0, 20'h0_4000, 0, 24'h00_0010);
    wr(exc_seq_pkg::REG_CTRL, 16'h0001);
    fire(0, 20'h0_4000, 0, 24'h00_0110);
    for (int k = 0; k < 6; k++) begin
      rnd = xs(rnd);
      s = rnd[3:0];
      gap <= rnd[27:24];
      status_low_in <= rnd[31:24];
      irq_pri <= {rnd[15:0], rnd} | (48'h1 << (3 * s));
      wr(exc_seq_pkg::REG_CTRL, {15'h0000, k[0]});
      wr(exc_seq_pkg::REG_ENABLES, 16'h1 << s);
      exp_v = (k[0] ? exc_seq_pkg::ALT_VEC_BASE : exc_seq_pkg::PRIMARY_VEC_BASE)
        + {19'h0, s, 1'b0};
      fire(16'h1 << s, 0, 0, exp_v + 24'h00_0010);
    end
    wr(exc_seq_pkg::REG_CTRL, 16'h0000);
    irq_pri <= (48'h5 << 6) | (48'h5 << 27);
    wr(exc_seq_pkg::REG_ENABLES, 16'h0204);
    fire(16'h0204, 0, 0, 24'h00_0018);
    wr(exc_seq_pkg::REG_STATUS, 16'h0007);
    irq_pri <= 48'h7;
    wr(exc_seq_pkg::REG_ENABLES, 16'h0001);
    fire(16'h0001, 0, 0, 24'h00_0000);
    fire(0, 20'h0_0001, 0, 24'h00_000a);
    wr(exc_seq_pkg::REG_STATUS, 16'h0000);
    vq.push_back(24'h00_0010);
    ev <= 20'h0_4000;
    @(posedge clk_in);
    ev <= 20'h0_0000;
    for (int n = 0; n < 60 && vq.size() > 0; n++) @(posedge clk_in);
    fire(0, 20'h0_2000, 16'h0000, 24'h00_0000);
    rd(exc_seq_pkg::REG_RESET_CTRL, 16'h8010);
    wr(exc_seq_pkg::REG_RESET_CTRL, 16'h0000);
    fire(0, 20'h6_0000, 0, 24'h00_0000);
    rd(exc_seq_pkg::REG_RESET_CTRL, 16'h0000);
    for (int k = 0; k < 4; k++) begin
      wr(exc_seq_pkg::REG_RESET_CTRL, 16'h0000);
      fire(0, 20'h1 << (k == 3 ? 19 : 15 + k), 0, 24'h00_0000);
      rd(exc_seq_pkg::REG_RESET_CTRL, 16'h1 << k);
    end
    test_done();
  end
endmodule : testbench
